//--- rtl/dmrc_edge.sv
// Purpose: Two-flop synchroniser with rising-edge detection.
// Assumes: Input is asynchronous to clk_i.
// Notes: Edge pulse is one clk_i cycle, one to two cycles after the pin.
`timescale 1ns/1ps
module dmrc_edge (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  logic meta;
  logic sync;
  logic prev;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_i;
      sync <= meta;
      prev <= sync;
    end
  end
  assign level_o = sync;
  assign rise_o = sync & ~prev;
endmodule : dmrc_edge

//--- rtl/dmrc_pkg.sv
// Purpose: Constants for the DRAM mode-register configuration block.
// Assumes: Command pins are sampled on rising edges of the command clock.
// Notes: Field positions are address-bit indices within a mode-register load.
package dmrc_pkg;
  localparam int DMRC_ADDR_W = 16;
  localparam int DMRC_BANK_W = 3;
  // Bank selects
  localparam logic [2:0] DMRC_BANK_MR0 = 3'h0;
  localparam logic [2:0] DMRC_BANK_MR1 = 3'h1;
  localparam logic [2:0] DMRC_BANK_MR2 = 3'h2;
  localparam logic [2:0] DMRC_BANK_MR3 = 3'h3;
  // First register fields
  localparam int DMRC_WR_LSB = 9;
  localparam int DMRC_PD_FAST_BIT = 12;
  // Second register fields
  localparam int DMRC_DLL_DIS_BIT = 0;
  localparam int DMRC_DRV0_BIT = 1;
  localparam int DMRC_DRV1_BIT = 5;
  localparam int DMRC_NOM0_BIT = 2;
  localparam int DMRC_NOM1_BIT = 6;
  localparam int DMRC_NOM2_BIT = 9;
  localparam int DMRC_AL_LSB = 3;
  localparam int DMRC_WLEV_BIT = 7;
  localparam int DMRC_QOFF_BIT = 12;
  // Third register fields
  localparam int DMRC_PARTIAL_ARRAY_SELF_REFRESH_LSB = 0;
  localparam int DMRC_CWL_LSB = 3;
  localparam int DMRC_RTTWR_LSB = 9;
  // Fourth register fields
  localparam int DMRC_CAL_LOC_LSB = 0;
  localparam int DMRC_CAL_EN_BIT = 2;
  // Encodings
  localparam logic [1:0] DMRC_AL_ZERO = 2'h0;
  localparam logic [1:0] DMRC_AL_CLM1 = 2'h1;
  localparam logic [1:0] DMRC_AL_CLM2 = 2'h2;
  localparam logic [2:0] DMRC_WR_ENC_BASE = 3'h5;
  localparam logic [4:0] DMRC_CWL_BASE = 5'h05;
  localparam logic [4:0] DMRC_ONE = 5'h01;
  localparam logic [4:0] DMRC_TWO = 5'h02;
  localparam logic [15:0] DMRC_MR_RESET = 16'h0000;
  // Write-recovery encoding 0 stands for 16 cycles
  localparam logic [4:0] DMRC_WR_ZERO_CYC = 5'h10;
endpackage : dmrc_pkg

//--- rtl/dmrc_top.sv
// Purpose: Mode-register load and decode for a DDR3-class DRAM device.
// Assumes: Command clock and pins are slow against clk_i and sampled by it.
// Notes: Pins are captured on each command-clock rising edge seen by clk_i.
`timescale 1ns/1ps
module dmrc_top
  import dmrc_pkg::*;
#(
  parameter int ADDR_W = DMRC_ADDR_W
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ck_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [DMRC_BANK_W-1:0] ba_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [4:0] cas_latency_i,
  input wire logic [4:0] row_precharge_time_i,
  input wire logic self_refresh_i,
  input wire logic power_down_i,
  input wire logic write_active_i,
  input wire logic odt_i,
  output logic [4:0] autoprecharge_write_to_activate_delay_o,
  output logic dll_on_o,
  output logic fast_exit_o,
  output logic [1:0] drive_sel_o,
  output logic [2:0] nominal_termination_o,
  output logic [1:0] write_termination_o,
  output logic [1:0] term_active_o,
  output logic [4:0] additive_latency_o,
  output logic additive_reserved_o,
  output logic [4:0] read_latency_o,
  output logic [4:0] write_latency_o,
  output logic [4:0] cas_write_latency_o,
  output logic write_leveling_o,
  output logic outputs_off_o,
  output logic [2:0] partial_array_self_refresh_o,
  output logic calibration_pattern_register_o,
  output logic [1:0] cal_loc_o
);
  logic ck_lvl;
  logic ck_rise;
  logic cke_s;
  logic cs_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic [DMRC_BANK_W-1:0] ba_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DMRC_BANK_W-1:0] ba_m;
  logic [ADDR_W-1:0] addr_m;
  logic [4:0] ctl_m;
  logic [4:0] ctl_s;
  logic [2:0] side_m;
  logic [2:0] side_s;
  logic [ADDR_W-1:0] mr0;
  logic [ADDR_W-1:0] mr1;
  logic [ADDR_W-1:0] mr2;
  logic [ADDR_W-1:0] mr3;

  // Command clock edge finder; data pins get their own two-flop stage
  dmrc_edge u_ck (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i(ck_i),
    .level_o(ck_lvl),
    .rise_o(ck_rise)
  );

  // Pins are bused through two flops; the controller holds them across a CK edge,
  // so bit-skew within the bus settles before the edge is seen.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl_m <= 5'h1f;
      ctl_s <= 5'h1f;
      ba_m <= '0;
      ba_s <= '0;
      addr_m <= '0;
      addr_s <= '0;
      side_m <= 3'h0;
      side_s <= 3'h0;
    end else begin
      ctl_m <= {~cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i};
      ctl_s <= ctl_m;
      ba_m <= ba_i;
      ba_s <= ba_m;
      addr_m <= addr_i;
      addr_s <= addr_m;
      side_m <= {self_refresh_i, write_active_i, odt_i};
      side_s <= side_m;
    end
  end
  assign cke_s = ~ctl_s[4];
  assign cs_n_s = ctl_s[3];
  assign ras_n_s = ctl_s[2];
  assign cas_n_s = ctl_s[1];
  assign we_n_s = ctl_s[0];

  wire mrs_cmd = ck_rise & cke_s & ~cs_n_s & ~ras_n_s & ~cas_n_s & ~we_n_s;
  wire ld_mr0 = mrs_cmd & (ba_s == DMRC_BANK_MR0);
  wire ld_mr1 = mrs_cmd & (ba_s == DMRC_BANK_MR1);
  wire ld_mr2 = mrs_cmd & (ba_s == DMRC_BANK_MR2);
  wire ld_mr3 = mrs_cmd & (ba_s == DMRC_BANK_MR3);

  // Registers hold until the same bank is addressed again
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mr0 <= DMRC_MR_RESET;
      mr1 <= DMRC_MR_RESET;
      mr2 <= DMRC_MR_RESET;
      mr3 <= DMRC_MR_RESET;
    end else begin
      if (ld_mr0) mr0 <= addr_s;
      if (ld_mr1) mr1 <= addr_s;
      if (ld_mr2) mr2 <= addr_s;
      if (ld_mr3) mr3 <= addr_s;
    end
  end

  // Field decode
  wire [2:0] wr_enc = mr0[DMRC_WR_LSB +: 3];
  wire [4:0] wr_cyc = (wr_enc == 3'h0) ? DMRC_WR_ZERO_CYC :
    (wr_enc < 3'h4) ? 5'({2'h0, wr_enc} + {2'h0, DMRC_WR_ENC_BASE} - DMRC_ONE) :
    5'({2'h0, wr_enc} << 1);
  wire [4:0] next_dal = 5'(wr_cyc + row_precharge_time_i);
  wire pd_fast = mr0[DMRC_PD_FAST_BIT];
  wire dll_disable = mr1[DMRC_DLL_DIS_BIT];
  wire self_ref = side_s[2];
  // DLL drops on self-refresh or slow-exit power-down, else follows the enable
  wire next_dll_on = ~dll_disable & ~self_ref & ~(power_down_i & ~pd_fast);
  wire [1:0] al_enc = mr1[DMRC_AL_LSB +: 2];
  wire [4:0] next_al = (al_enc == DMRC_AL_CLM1) ? 5'(cas_latency_i - DMRC_ONE) :
    (al_enc == DMRC_AL_CLM2) ? 5'(cas_latency_i - DMRC_TWO) : 5'h00;
  wire al_res = (al_enc == 2'h3);
  wire [4:0] next_cwl = 5'({2'h0, mr2[DMRC_CWL_LSB +: 3]} + DMRC_CWL_BASE);
  wire wlev = mr1[DMRC_WLEV_BIT];
  wire [2:0] nom = {mr1[DMRC_NOM2_BIT], mr1[DMRC_NOM1_BIT], mr1[DMRC_NOM0_BIT]};
  wire [1:0] write_termination = mr2[DMRC_RTTWR_LSB +: 2];
  // Termination in use: bit1 write value, bit0 nominal value
  wire use_wr = side_s[0] & side_s[1] & ~wlev & (write_termination != 2'h0);
  wire use_nom = side_s[0] & ~use_wr & (nom != 3'h0);
  wire cal_en = mr3[DMRC_CAL_EN_BIT];
  wire [1:0] next_loc = cal_en ? mr3[DMRC_CAL_LOC_LSB +: 2] : 2'h0;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      autoprecharge_write_to_activate_delay_o <= '0;
      dll_on_o <= 1'b0;
      fast_exit_o <= 1'b0;
      drive_sel_o <= '0;
      nominal_termination_o <= '0;
      write_termination_o <= '0;
      term_active_o <= '0;
      additive_latency_o <= '0;
      additive_reserved_o <= 1'b0;
      read_latency_o <= '0;
      write_latency_o <= '0;
      cas_write_latency_o <= '0;
      write_leveling_o <= 1'b0;
      outputs_off_o <= 1'b0;
      partial_array_self_refresh_o <= '0;
      calibration_pattern_register_o <= 1'b0;
      cal_loc_o <= '0;
    end else begin
      autoprecharge_write_to_activate_delay_o <= next_dal;
      dll_on_o <= next_dll_on;
      fast_exit_o <= pd_fast;
      drive_sel_o <= {mr1[DMRC_DRV1_BIT], mr1[DMRC_DRV0_BIT]};
      nominal_termination_o <= nom;
      write_termination_o <= write_termination;
      term_active_o <= {use_wr, use_nom};
      additive_latency_o <= next_al;
      additive_reserved_o <= al_res;
      read_latency_o <= 5'(next_al + cas_latency_i);
      write_latency_o <= 5'(next_al + next_cwl);
      cas_write_latency_o <= next_cwl;
      write_leveling_o <= wlev;
      outputs_off_o <= mr1[DMRC_QOFF_BIT];
      // Range only matters once self-refresh is entered; retention outside it is not kept
      partial_array_self_refresh_o <= mr2[DMRC_PARTIAL_ARRAY_SELF_REFRESH_LSB +: 3];
      calibration_pattern_register_o <= cal_en;
      cal_loc_o <= next_loc;
    end
  end
  // Unused level kept for future half-cycle capture
  wire unused_ok = ck_lvl;
endmodule : dmrc_top

//--- verif/dmrc_checker.sv
// Purpose: Port assertions for the mode-register block.
// Assumes: Command clock far slower than clk_i.
// Notes: Short waits cover the pin synchronisers.
`timescale 1ns/1ps
module dmrc_checker (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ck_i,
  input wire logic [4:0] cas_latency_i,
  input wire logic [4:0] row_precharge_time_i,
  input wire logic self_refresh_i,
  input wire logic power_down_i,
  input wire logic [4:0] autoprecharge_write_to_activate_delay_o,
  input wire logic dll_on_o,
  input wire logic fast_exit_o,
  input wire logic [1:0] term_active_o,
  input wire logic [4:0] additive_latency_o,
  input wire logic additive_reserved_o,
  input wire logic [4:0] read_latency_o,
  input wire logic write_leveling_o,
  input wire logic calibration_pattern_register_o,
  input wire logic [1:0] cal_loc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_wr; $stable(row_precharge_time_i)[*4] |-> autoprecharge_write_to_activate_delay_o
    inside {[row_precharge_time_i + 5'h05 : row_precharge_time_i + 5'h10]}; endproperty
  a_wr: assert property (p_wr) else $error("write-to-activate delay out of range");
  property p_rl; (!additive_reserved_o && $stable({cas_latency_i, additive_latency_o}))[*3]
    |-> read_latency_o == 5'(additive_latency_o + cas_latency_i); endproperty
  a_rl: assert property (p_rl) else $error("read latency sum wrong");
  property p_al; (!additive_reserved_o && additive_latency_o != 5'h00 && $stable(cas_latency_i))[*3]
    |-> additive_latency_o inside {cas_latency_i - 5'h01, cas_latency_i - 5'h02}; endproperty
  a_al: assert property (p_al) else $error("additive latency decode wrong");
  property p_cal; !calibration_pattern_register_o |-> cal_loc_o == 2'h0; endproperty
  a_cal: assert property (p_cal) else $error("location shown while disabled");
  property p_lev; write_leveling_o[*3] |-> !term_active_o[1]; endproperty
  a_lev: assert property (p_lev) else $error("write termination during leveling");
  property p_sr; self_refresh_i[*6] |-> !dll_on_o; endproperty
  a_sr: assert property (p_sr) else $error("delay loop on in self-refresh");
  property p_pd; (power_down_i && !fast_exit_o)[*3] |-> !dll_on_o; endproperty
  a_pd: assert property (p_pd) else $error("delay loop on in slow power-down");
  property p_hold; (!ck_i)[*8] |-> $stable({fast_exit_o, calibration_pattern_register_o, cal_loc_o});
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without load");
  c_lev: cover property (write_leveling_o);
  c_res: cover property (additive_reserved_o);
  c_cal: cover property (calibration_pattern_register_o && cal_loc_o != 2'h0);
endmodule : dmrc_checker
bind dmrc_top dmrc_checker u_chk (.*);

//--- verif/dmrc_ctrl_model.sv
// Purpose: Controller model issuing mode-register-set commands.
// Assumes: Clock enable stays high throughout.
// Notes: Command clock runs only within a frame; released address shows its inverse.
`timescale 1ns/1ps
module dmrc_ctrl_model (
  input wire logic clk_i,
  output logic ck_o,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [15:0] addr_o,
  output logic done_o
);
  logic dll_off = 1'b0;
  // Smallest write-recovery code the modelled part may use
  localparam logic [2:0] WR_MIN_CODE = 3'h1;
  initial begin
    {ck_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, done_o} = 7'h3e;
    {ba_o, addr_o} = 19'h00000;
  end
  task automatic mode_register_set(input logic [1:0] sel, input logic [15:0] a, input logic bad,
                     output logic [15:0] v);
    v = a & ((sel == 2'h0) ? 16'h1fff : (sel == 2'h1) ? 16'h12ff :
      (sel == 2'h2) ? 16'h06df : 16'h0007);
    if (sel == 2'h0 && v[11:9] != 3'h0 && v[11:9] < WR_MIN_CODE) begin
      v[11:9] = WR_MIN_CODE;
    end
    if (sel == 2'h1 && v[7] && !v[12]) begin
      v[9] = 1'b0;
      v[2] = v[2] | !v[6];
    end
    if (sel == 2'h1 && v[0]) begin
      v = v & 16'hfd3b;
    end
    if (sel == 2'h2 && dll_off) begin
      v[10:9] = 2'h0;
    end
    if (sel == 2'h1 && !bad) begin
      dll_off = v[0];
    end
    @(posedge clk_i);
    done_o <= 1'b0;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= {3'h0, bad};
    ba_o <= {1'b0, sel};
    addr_o <= v;
    #33.3;
    ck_o <= 1'b1;
    #32;
    ck_o <= 1'b0;
    @(posedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hf;
    addr_o <= ~v;
    done_o <= 1'b1;
  endtask : mode_register_set
endmodule : dmrc_ctrl_model

//--- verif/tb.sv
// Purpose: Random mode-register loads checked against a shadow copy.
// Assumes: Inputs change only between loads.
// Notes: Nominal termination activity is expected only when write termination is idle.
`timescale 1ns/1ps
module tb;
  import dmrc_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ck, cke, cs_n, ras_n, cas_n, we_n, done, done_q = 1'b0;
  logic [2:0] ba, nom, partial_array_self_refresh;
  logic [15:0] addr, v;
  logic [15:0] mr [4] = '{default: 16'h0000};
  logic [4:0] cl = 5'h05, rp = 5'h00, dly, alo, rlo, wlo, cwlo;
  logic sr = 1'b0, pd = 1'b0, on_die_termination = 1'b0, wa = 1'b0, dllo, fsto, resv, wlev, qoff, calo;
  logic [1:0] drv, wto, tao, loc;
  logic [44:0] expq [$];
  logic [31:0] seed = 32'h00003a18;
  int failures = 0, compares = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  dmrc_ctrl_model u_ctrl (.clk_i(clk_i), .ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .done_o(done));
  dmrc_top dut (.clk_i(clk_i), .srst_i(srst_i), .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr),
    .cas_latency_i(cl), .row_precharge_time_i(rp), .self_refresh_i(sr), .power_down_i(pd),
    .write_active_i(wa), .odt_i(on_die_termination), .autoprecharge_write_to_activate_delay_o(dly),
    .dll_on_o(dllo), .fast_exit_o(fsto), .drive_sel_o(drv), .nominal_termination_o(nom),
    .write_termination_o(wto), .term_active_o(tao), .additive_latency_o(alo),
    .additive_reserved_o(resv), .read_latency_o(rlo), .write_latency_o(wlo),
    .cas_write_latency_o(cwlo), .write_leveling_o(wlev), .outputs_off_o(qoff),
    .partial_array_self_refresh_o(partial_array_self_refresh), .calibration_pattern_register_o(calo), .cal_loc_o(loc));
  wire [44:0] got_vec = {dly, fsto, dllo, drv, nom, wto, tao,
    resv ? 15'h0000 : {alo, rlo, wlo}, resv, cwlo, wlev, qoff, partial_array_self_refresh, calo, loc};
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [44:0] exp_vec();
    logic [2:0] w;
    logic [4:0] wrc, al, cas_write_latency;
    logic wt;
    w = mr[0][11:9];
    wrc = (w == 3'h0) ? 5'h10 : (w < 3'h4) ? 5'(w) + 5'h04 : {1'b0, w, 1'b0};
    al = (mr[1][4:3] == 2'h1) ? cl - 5'h01 : (mr[1][4:3] == 2'h2) ? cl - 5'h02 : 5'h00;
    cas_write_latency = 5'(mr[2][5:3]) + 5'h05;
    wt = on_die_termination && wa && !mr[1][7] && mr[2][10:9] != 2'h0;
    return {5'(wrc + rp), mr[0][12], !mr[1][0] && !sr && !(pd && !mr[0][12]), mr[1][5],
      mr[1][1], mr[1][9], mr[1][6], mr[1][2], mr[2][10:9],
      wt, on_die_termination && !wt && {mr[1][9], mr[1][6], mr[1][2]} != 3'h0,
      (mr[1][4:3] == 2'h3) ? 15'h0000 : {al, 5'(al + cl), 5'(al + cas_write_latency)},
      mr[1][4:3] == 2'h3, cas_write_latency, mr[1][7], mr[1][12], mr[2][2:0], mr[3][2],
      mr[3][2] ? mr[3][1:0] : 2'h0};
  endfunction : exp_vec
  task automatic cmp(input logic [44:0] got, input logic [44:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  always @(posedge clk_i) begin
    done_q <= done;
    cycles <= cycles + 1;
    if (done && !done_q && expq.size() > 0) begin
      cmp(got_vec, expq.pop_front());
    end
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 60; i++) begin
      repeat (2) @(posedge clk_i);
      r = xs();
      cl <= 5'(5'h05 + r[3:0] % 4'ha);
      {sr, pd, on_die_termination, wa} <= r[11:8];
      rp <= {1'b0, r[15:12]};
      u_ctrl.mode_register_set(r[5:4], r[31:16], r[19:16] == 4'h0, v);
      if (r[19:16] != 4'h0) begin
        mr[r[5:4]] = v;
      end
      expq.push_back(exp_vec());
    end
    repeat (4) @(posedge clk_i);
    $display("random mode register test done");
    summarize();
  end
endmodule : tb
